// file: spbc_break_det.sv
`timescale 1ns/10ps
// Break detector: counts bit periods while rx stays at space level
module spbc_break_det import spbc_pkg::*; (
	input wire logic clk, // Clock
	input wire logic reset_n, // Sync reset, low
	input wire logic rx, // Data port receive, space is low
	input wire logic qtick, // Quarter-bit enable at active baud
	input wire logic [3:0] char_bits, // Bits per character
	output logic brk // One-cycle pulse on break
);
	logic [1:0] qcnt;
	logic [5:0] bits;
	logic fired;

	// Bits of continuous space; fires once per low spell
	always_ff @(posedge clk) begin
		if (!reset_n || rx) begin
			qcnt <= '0;
			bits <= '0;
			fired <= 1'b0;
			brk <= 1'b0;
		end else begin
			brk <= 1'b0;
			if (qtick) begin
				qcnt <= qcnt + 2'd1;
				if (qcnt == 2'd3 && bits != 6'h3F) begin
					bits <= bits + 6'd1;
				end
			end
			if (!fired && bits > {2'b00, char_bits}) begin
				fired <= 1'b1;
				brk <= 1'b1;
			end
		end
	end

	a_break_needs_low: assert property (@(posedge clk) disable iff (!reset_n)
		brk |-> $past(!rx, 1) && $past(!rx, 2)) else $error("Break without low line");
endmodule

// file: spbc_end_dev.sv
`timescale 1ns/10ps
// End device on the data port: idles at mark, sends a space span on request
module spbc_end_dev (
	input wire logic clk, // Clock
	input wire logic brk_go, // Start a space span
	input wire logic [15:0] brk_cyc, // Span length in cycles
	output logic rx_line // Line into the data port
);
	int left = 0;
	// Count down the space span
	always @(posedge clk) begin
		if (brk_go) begin
			left <= brk_cyc;
		end else if (left > 0) begin
			left <= left - 1;
		end
	end
	// Space is low, mark otherwise
	assign rx_line = (left == 0);
endmodule

// file: spbc_pkg.sv
package spbc_pkg;
	// Avalon register word offsets (byte addresses)
	localparam logic [3:0] SPBC_REG_CTRL = 4'h0;
	localparam logic [3:0] SPBC_REG_TIMING = 4'h4;
	localparam logic [3:0] SPBC_REG_STATUS = 4'h8;
	localparam logic [3:0] SPBC_REG_BAUD = 4'hC;
	// CTRL fields
	localparam int SPBC_CTRL_PORTSEL_LSB = 0;
	localparam int SPBC_CTRL_IFACE_LSB = 2;
	localparam int SPBC_CTRL_BREAK_LSB = 4;
	localparam int SPBC_CTRL_SLAVE_BIT = 6;
	localparam int SPBC_CTRL_CLRSETUP_BIT = 7;
	// TIMING fields
	localparam int SPBC_TIM_OFF_LSB = 0;
	localparam int SPBC_TIM_ON_LSB = 4;
	localparam int SPBC_TIM_BITS_LSB = 8;
	// Reset values
	localparam logic [1:0] SPBC_PORTSEL_RST = 2'h3;
	localparam logic [3:0] SPBC_OFF_RST = 4'h0;
	localparam logic [3:0] SPBC_ON_RST = 4'h0;
	localparam logic [1:0] SPBC_BREAK_RST = 2'h0;
	localparam logic [3:0] SPBC_BITS_RST = 4'hA;
	localparam logic [15:0] SPBC_BAUD_RST = 16'h0412;
	// Port selector, interface and break codes, delay limits
	localparam logic [1:0] SPBC_SEL_DATA = 2'h1;
	localparam logic [1:0] SPBC_SEL_DIAG = 2'h2;
	localparam logic [1:0] SPBC_SEL_BOTH = 2'h3;
	localparam logic [1:0] SPBC_IF_RS232 = 2'h0;
	localparam logic [1:0] SPBC_IF_DOT = 2'h3;
	localparam logic [1:0] SPBC_BRK_OFF = 2'h0;
	localparam logic [1:0] SPBC_BRK_FIXED = 2'h1;
	localparam logic [3:0] SPBC_OFF_MAX = 4'h9;
	localparam logic [3:0] SPBC_OFF_FULL = 4'h4;
	localparam logic [3:0] SPBC_ON_MAX = 4'h9;
	// Timing
	localparam int SPBC_CLK_HZ = 200_000_000;
	localparam int SPBC_MS_NUM = 1;
	localparam int SPBC_MS_CYC = SPBC_CLK_HZ / 1000 * SPBC_MS_NUM;
	localparam int SPBC_SLOW_BAUD = 1200;
	localparam int SPBC_SETUP_BAUD = 19200;
	localparam logic [15:0] SPBC_SLOW_DIV = 16'((SPBC_CLK_HZ / 4) / SPBC_SLOW_BAUD);
	localparam logic [15:0] SPBC_SETUP_DIV = 16'((SPBC_CLK_HZ / 4) / SPBC_SETUP_BAUD);
endpackage

// file: spbc_tb_top.sv
`timescale 1ns/10ps
module spbc_tb_top import spbc_pkg::*; ;
	localparam int MSC = 10;
	localparam int DIV = 256;
	localparam int BITS = 2;
	logic clk, reset_n, avs_read, avs_write, avs_waitrequest, tx_req, tx_char_done;
	logic tx_go, drv_en, rx_data, req_d, req_g, gr_d, gr_g, smode, sfix, brk_go, slv;
	logic [1:0] ifc;
	logic [3:0] avs_address, avs_byteenable, on, off;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [15:0] brk_cyc;
	int error_cnt = 0;
	int n_checks = 0;
	spbc_top #(.MS_CYCLES(MSC)) dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tx_req(tx_req), .tx_char_done(tx_char_done),
		.tx_go(tx_go), .drv_en(drv_en), .rx_data(rx_data), .setup_req_data(req_d),
		.setup_req_diag(req_g), .setup_grant_data(gr_d), .setup_grant_diag(gr_g),
		.setup_mode(smode), .setup_fixed_baud(sfix));
	spbc_end_dev far (.clk(clk), .brk_go(brk_go), .brk_cyc(brk_cyc), .rx_line(rx_data));
	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Verdict and end of run
	task automatic stop_test();
		if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// Cycle count compare with tolerance
	task automatic chk_near(input int got, input int exp, input int tol, input string m);
		n_checks++;
		if (got < exp - tol || got > exp + tol) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %0d exp %0d", $time, m, got, exp);
		end
	endtask
	// One bus transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// Read and compare
	task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string m);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp, m);
	endtask
	// Write both setting registers
	task automatic cfg(input logic [1:0] sel, input logic [1:0] fc, input logic [1:0] brk,
		input logic sl, input logic [3:0] of, input logic [3:0] onv);
		bus(1'b1, SPBC_REG_CTRL, {24'h0, 1'b0, sl, brk, fc, sel});
		bus(1'b1, SPBC_REG_TIMING, {20'h0, 4'(BITS), onv, of});
	endtask
	// Expected lead span in cycles
	function automatic int lead_of(input logic [1:0] fc, input logic sl, input logic [3:0] o);
		return (fc != SPBC_IF_DOT || sl) ? int'(o) * MSC : 0;
	endfunction
	// Expected hold span in cycles: quarter-characters of BITS quarter-bits each
	function automatic int hold_of(input logic [3:0] o);
		int q;
		q = int'(o);
		if (DIV >= int'(SPBC_SLOW_DIV) && q > 4) q = q - 4;
		return q * BITS * DIV;
	endfunction
	// One character: measure lead span and hold span
	task automatic xfer(input int lead, input int hold);
		int c;
		c = 0;
		@(posedge clk);
		tx_req <= 1'b1;
		@(posedge clk);
		repeat (2000) begin
			@(posedge clk);
			if (tx_go === 1'b1) break;
			c++;
		end
		chk_near(c, lead, 2, "lead span");
		chk({31'h0, drv_en}, 32'h0000_0001, "driver on");
		repeat (3) @(posedge clk);
		tx_req <= 1'b0;
		tx_char_done <= 1'b1;
		@(posedge clk);
		tx_char_done <= 1'b0;
		c = 0;
		repeat (6000) begin
			@(posedge clk);
			if (drv_en !== 1'b1) break;
			c++;
		end
		chk_near(c, hold, DIV + 2, "hold span");
		chk({31'h0, tx_go}, 32'h0000_0000, "send stopped");
	endtask
	// Hang guard
	initial begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
	// Main sequence
	initial begin
		{reset_n, avs_read, avs_write, tx_req, tx_char_done, req_d, req_g, brk_go} = 8'h00;
		avs_address = 4'h0;
		avs_byteenable = 4'hF;
		avs_writedata = 32'h0000_0000;
		brk_cyc = 16'h0000;
		void'($urandom(32'h8ef6));
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		rchk(SPBC_REG_CTRL, 32'h0000_0003, "ctrl reset");
		rchk(SPBC_REG_TIMING, 32'h0000_0A00, "timing reset");
		rchk(SPBC_REG_BAUD, 32'h0000_0412, "baud reset");
		rchk(SPBC_REG_STATUS, 32'h0000_0000, "status idle");
		rchk(4'h2, 32'h0000_0000, "unmapped");
		req_d <= 1'b1;
		req_g <= 1'b1;
		for (int s = 1; s < 4; s++) begin
			cfg(s[1:0], SPBC_IF_RS232, SPBC_BRK_OFF, 1'b0, 4'h0, 4'h0);
			repeat (2) @(posedge clk);
			chk({30'h0, gr_g, gr_d}, {30'h0, s[1:0]}, "grants");
		end
		cfg(2'h0, SPBC_IF_RS232, SPBC_BRK_OFF, 1'b0, 4'hF, 4'hF);
		rchk(SPBC_REG_CTRL, 32'h0000_0003, "selector kept");
		rchk(SPBC_REG_TIMING, 32'h0000_0299, "delay clip");
		// Slow rate with a wrapping release setting, then back to the fast divisor
		cfg(SPBC_SEL_DIAG, SPBC_IF_RS232, SPBC_BRK_OFF, 1'b0, 4'h5, 4'h0);
		bus(1'b1, SPBC_REG_BAUD, 32'h0000_A400);
		rchk(SPBC_REG_BAUD, 32'h0000_A400, "slow baud");
		bus(1'b1, SPBC_REG_BAUD, 32'(DIV));
		rchk(SPBC_REG_BAUD, 32'(DIV), "fast baud");
		for (int i = 0; i < 6; i++) begin
			ifc = (i % 2) ? 2'h2 : SPBC_IF_DOT;
			slv = 1'($urandom % 2);
			on = 4'($urandom % 10);
			off = (i % 2) ? 4'(4 + $urandom % 6) : 4'($urandom % 10);
			if (i == 0) {slv, on, off} = {1'b0, 4'h9, 4'h0};
			if (i == 1) {slv, on, off} = {1'b0, 4'h2, 4'h4};
			cfg(SPBC_SEL_DIAG, ifc, SPBC_BRK_OFF, slv, off, on);
			xfer(lead_of(ifc, slv, on), hold_of(off));
		end
		for (int o = 0; o < 3; o++) begin
			cfg(SPBC_SEL_DIAG, SPBC_IF_RS232, o[1:0], 1'b0, 4'h0, 4'h0);
			for (int k = 0; k < 2; k++) begin
				// Short span 1.5 bits, long span 4 bits, against a 2-bit character
				brk_cyc <= k ? 16'd4096 : 16'd1536;
				brk_go <= 1'b1;
				@(posedge clk);
				brk_go <= 1'b0;
				repeat (int'(brk_cyc) + 400) @(posedge clk);
				chk({31'h0, smode}, {31'h0, k == 1 && o != 0}, "setup mode");
				chk({31'h0, sfix}, {31'h0, k == 1 && o == 1}, "fixed rate");
			end
			bus(1'b1, SPBC_REG_CTRL, {24'h0, 1'b1, 1'b0, o[1:0], SPBC_IF_RS232, SPBC_SEL_DIAG});
			repeat (2) @(posedge clk);
			chk({31'h0, smode}, 32'h0000_0000, "setup left");
		end
		stop_test();
	end
endmodule

// file: spbc_tick_div.sv
`timescale 1ns/10ps
// Pulse generator: one-cycle enable every div cycles, restartable
module spbc_tick_div import spbc_pkg::*; #(
	parameter int W = 20
) (
	input wire logic clk, // Clock
	input wire logic reset_n, // Sync reset, low
	input wire logic run, // Count while high
	input wire logic [W-1:0] div, // Period in cycles, 1 or more
	output logic tick // Enable pulse
);
	initial begin
		if (W < 2) $error("W too small");
	end
	logic [W-1:0] cnt;

	// Counts up and pulses on the last cycle of each period
	always_ff @(posedge clk) begin
		if (!reset_n || !run) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt + W'(1) >= div) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + W'(1);
			tick <= 1'b0;
		end
	end
endmodule

// file: spbc_top.sv
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// - Selector routes setup: 1 data, 2 diag, 3 both
// - Hold driver release delay after last character
// - Release delay quarter-characters, 0..9, default 0
// - Setting 4 equals one full character
// - At 1200 baud or slower, 5..9 wrap
// - Enable drivers, wait lead ms before data
// - Break option: 0 off, 1 19200, 2 current
// - Break detected on receive enters setup mode
// - Lead delay on every interface except DOT master
module spbc_top import spbc_pkg::*; #(
	parameter int MS_CYCLES = SPBC_MS_CYC // Cycles per millisecond
) (
	input wire logic clk, // 200 MHz clock
	input wire logic reset_n, // Sync reset, low
	input wire logic [3:0] avs_address, // Byte address
	input wire logic avs_read, // Read strobe
	input wire logic avs_write, // Write strobe
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte enables
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire logic tx_req, // UART has a character to send
	input wire logic tx_char_done, // Pulse: last stop bit sent
	output logic tx_go, // Lead delay done, send allowed
	output logic drv_en, // Line driver enable
	input wire logic rx_data, // Data port receive line
	input wire logic setup_req_data, // Setup request on data port
	input wire logic setup_req_diag, // Setup request on diag port
	output logic setup_grant_data, // Setup accepted on data port
	output logic setup_grant_diag, // Setup accepted on diag port
	output logic setup_mode, // Setup mode active
	output logic setup_fixed_baud // Setup runs at 19200 bps
);
	initial begin
		if (MS_CYCLES < 1 || MS_CYCLES > 1_000_000) $error("MS_CYCLES out of range");
	end

	typedef enum logic [1:0] {SPBC_IDLE, SPBC_LEAD, SPBC_SEND, SPBC_HOLD} spbc_state_e;

	logic [1:0] port_sel;
	logic [1:0] iface;
	logic [1:0] brk_opt;
	logic is_slave;
	logic [3:0] off_dly;
	logic [3:0] on_dly;
	logic [3:0] char_bits;
	logic [15:0] baud_div;
	logic acc_done;
	spbc_state_e state;
	logic [19:0] ms_cnt;
	logic [3:0] on_cnt;
	logic [7:0] qc_cnt;
	logic [7:0] hold_q;
	logic qtick;
	logic brk_pulse;
	logic [15:0] act_div;

	// Clips a delay setting to its legal top value
	function automatic logic [3:0] spbc_clip(input logic [3:0] v, input logic [3:0] mx);
		return (v > mx) ? mx : v;
	endfunction

	// Quarter-bit timing at the active baud; setup at 19200 uses a fixed divisor
	assign act_div = (setup_mode && setup_fixed_baud) ? SPBC_SETUP_DIV : baud_div;

	spbc_tick_div #(.W(16)) u_qdiv (
		.clk(clk),
		.reset_n(reset_n),
		.run(1'b1),
		.div(act_div),
		.tick(qtick)
	);

	spbc_break_det u_brk (
		.clk(clk),
		.reset_n(reset_n),
		.rx(rx_data),
		.qtick(qtick),
		.char_bits(char_bits),
		.brk(brk_pulse)
	);

	// Quarter-characters of hold; slow rates wrap 5..9 down by 4
	always_comb begin
		logic [3:0] eff;
		eff = off_dly;
		if (baud_div >= SPBC_SLOW_DIV && off_dly > SPBC_OFF_FULL) begin
			eff = off_dly - SPBC_OFF_FULL;
		end
		hold_q = 8'(eff) * 8'(char_bits);
	end

	// Avalon slave: one wait cycle, answer on the second; waitrequest rests high
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			acc_done <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			acc_done <= (avs_read || avs_write) && !acc_done;
			avs_waitrequest <= !((avs_read || avs_write) && !acc_done);
		end
	end

	// Configuration registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			port_sel <= SPBC_PORTSEL_RST;
			iface <= SPBC_IF_RS232;
			brk_opt <= SPBC_BREAK_RST;
			is_slave <= 1'b0;
			off_dly <= SPBC_OFF_RST;
			on_dly <= SPBC_ON_RST;
			char_bits <= SPBC_BITS_RST;
			baud_div <= SPBC_BAUD_RST;
		end else if (avs_write && acc_done) begin
			if (avs_address == SPBC_REG_CTRL && avs_byteenable[0]) begin
				if (avs_writedata[SPBC_CTRL_PORTSEL_LSB +: 2] != 2'h0) begin
					port_sel <= avs_writedata[SPBC_CTRL_PORTSEL_LSB +: 2];
				end
				iface <= avs_writedata[SPBC_CTRL_IFACE_LSB +: 2];
				if (avs_writedata[SPBC_CTRL_BREAK_LSB +: 2] != 2'h3) begin
					brk_opt <= avs_writedata[SPBC_CTRL_BREAK_LSB +: 2];
				end
				is_slave <= avs_writedata[SPBC_CTRL_SLAVE_BIT];
			end
			if (avs_address == SPBC_REG_TIMING) begin
				if (avs_byteenable[0]) begin
					off_dly <= spbc_clip(avs_writedata[SPBC_TIM_OFF_LSB +: 4], SPBC_OFF_MAX);
					on_dly <= spbc_clip(avs_writedata[SPBC_TIM_ON_LSB +: 4], SPBC_ON_MAX);
				end
				if (avs_byteenable[1] && avs_writedata[SPBC_TIM_BITS_LSB +: 4] > 4'h1) begin
					char_bits <= avs_writedata[SPBC_TIM_BITS_LSB +: 4];
				end
			end
			if (avs_address == SPBC_REG_BAUD) begin
				if (avs_byteenable[0]) baud_div[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1] && avs_writedata[15:8] != 8'h00) begin
					baud_div[15:8] <= avs_writedata[15:8];
				end
			end
		end
	end

	// Read data, registered on the answering edge; unmapped reads zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			avs_readdata <= '0;
		end else if (avs_read && !acc_done) begin
			unique case (avs_address)
				SPBC_REG_CTRL: avs_readdata <= {24'h0000_00, 1'b0, is_slave, brk_opt, iface,
					port_sel};
				SPBC_REG_TIMING: avs_readdata <= {20'h0000_0, char_bits, on_dly, off_dly};
				SPBC_REG_STATUS: avs_readdata <= {26'h000_0000, setup_fixed_baud, setup_mode,
					state, tx_go, drv_en};
				SPBC_REG_BAUD: avs_readdata <= {16'h0000, baud_div};
				default: avs_readdata <= '0;
			endcase
		end
	end

	// Setup access routing by selector
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			setup_grant_data <= 1'b0;
			setup_grant_diag <= 1'b0;
		end else begin
			setup_grant_data <= setup_req_data && port_sel[0];
			setup_grant_diag <= setup_req_diag && port_sel[1];
		end
	end

	// Break entry into setup mode; software leaves setup via CTRL bit 7
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			setup_mode <= 1'b0;
			setup_fixed_baud <= 1'b0;
		end else if (brk_pulse && brk_opt != SPBC_BRK_OFF) begin
			setup_mode <= 1'b1;
			setup_fixed_baud <= (brk_opt == SPBC_BRK_FIXED);
		end else if (avs_write && acc_done && avs_address == SPBC_REG_CTRL
			&& avs_byteenable[0] && avs_writedata[SPBC_CTRL_CLRSETUP_BIT]) begin
			setup_mode <= 1'b0;
			setup_fixed_baud <= 1'b0;
		end
	end

	// Driver sequence: lead delay, send, release hold
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= SPBC_IDLE;
			drv_en <= 1'b0;
			tx_go <= 1'b0;
			ms_cnt <= '0;
			on_cnt <= '0;
			qc_cnt <= '0;
		end else begin
			unique case (state)
				SPBC_IDLE: begin
					ms_cnt <= '0;
					on_cnt <= '0;
					if (tx_req) begin
						drv_en <= 1'b1;
						if (on_dly != 4'h0 && (iface != SPBC_IF_DOT || is_slave)) begin
							state <= SPBC_LEAD;
						end else begin
							state <= SPBC_SEND;
							tx_go <= 1'b1;
						end
					end
				end
				SPBC_LEAD: begin
					if (ms_cnt == 20'(MS_CYCLES - 1)) begin
						ms_cnt <= '0;
						on_cnt <= on_cnt + 4'd1;
						if (on_cnt + 4'd1 == on_dly) begin
							state <= SPBC_SEND;
							tx_go <= 1'b1;
						end
					end else begin
						ms_cnt <= ms_cnt + 20'd1;
					end
				end
				SPBC_SEND: begin
					qc_cnt <= '0;
					if (tx_char_done && !tx_req) begin
						tx_go <= 1'b0;
						if (hold_q == 8'd0) begin
							state <= SPBC_IDLE;
							drv_en <= 1'b0;
						end else begin
							state <= SPBC_HOLD;
						end
					end
				end
				SPBC_HOLD: begin
					if (tx_req) begin
						state <= SPBC_SEND;
						tx_go <= 1'b1;
					end else if (qtick) begin
						qc_cnt <= qc_cnt + 8'd1;
						if (qc_cnt + 8'd1 >= hold_q) begin
							state <= SPBC_IDLE;
							drv_en <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	a_go_needs_drv: assert property (@(posedge clk) disable iff (!reset_n)
		tx_go |-> drv_en) else $error("Send allowed with driver off");
	a_hold_keeps_drv: assert property (@(posedge clk) disable iff (!reset_n)
		state == SPBC_HOLD |-> drv_en) else $error("Driver dropped during hold");
	a_zero_off_rel: assert property (@(posedge clk) disable iff (!reset_n)
		(state == SPBC_SEND && tx_char_done && !tx_req && hold_q == 8'd0)
		|=> !drv_en && state == SPBC_IDLE) else $error("Zero delay not immediate");
	a_lead_skip_master: assert property (@(posedge clk) disable iff (!reset_n)
		(state == SPBC_IDLE && tx_req && iface == SPBC_IF_DOT && !is_slave)
		|=> tx_go) else $error("Lead delay applied on master");
	a_lead_no_go: assert property (@(posedge clk) disable iff (!reset_n)
		state == SPBC_LEAD |-> !tx_go) else $error("Send during lead delay");
	a_break_enter: assert property (@(posedge clk) disable iff (!reset_n)
		(brk_pulse && brk_opt != SPBC_BRK_OFF) |=> setup_mode) else $error("Break ignored");
	a_break_off: assert property (@(posedge clk) disable iff (!reset_n)
		(brk_opt == SPBC_BRK_OFF && !setup_mode) |=> !setup_mode)
		else $error("Setup entered while disabled");
	a_diag_only: assert property (@(posedge clk) disable iff (!reset_n)
		port_sel == SPBC_SEL_DIAG |=> !setup_grant_data) else $error("Data port granted");
	a_full_char_hold: assert property (@(posedge clk) disable iff (!reset_n)
		(off_dly == SPBC_OFF_FULL) |-> hold_q == 8'(4 * char_bits))
		else $error("Setting 4 not one character");
	a_slow_wrap: assert property (@(posedge clk) disable iff (!reset_n)
		(baud_div >= SPBC_SLOW_DIV && off_dly > SPBC_OFF_FULL)
		|-> hold_q == 8'(off_dly - SPBC_OFF_FULL) * 8'(char_bits))
		else $error("Slow release delay not wrapped");

	c_lead_path: cover property (@(posedge clk) state == SPBC_LEAD ##1 state == SPBC_SEND);
	c_hold_end: cover property (@(posedge clk) state == SPBC_HOLD ##1 state == SPBC_IDLE);
	c_break_setup: cover property (@(posedge clk) $rose(setup_mode));
	c_both_grant: cover property (@(posedge clk) setup_grant_data && setup_grant_diag);
endmodule
